// file: avalon_host.sv
// Avalon-MM host model that reaches the interrupt block's registers
module avalon_host (
	input  wire logic        sys_clk,
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic             hang
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		hang = 1'b0;
	end
	// Request held until waitrequest is sampled low; a stuck slave raises hang
	task automatic cycle(input logic rnw, input logic [4:0] a, input logic [31:0] wd,
			output logic [31:0] rdat);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= rnw;
		avs_write <= !rnw;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		if (avs_waitrequest !== 1'b0) hang <= 1'b1;
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] wd);
		logic [31:0] unused;
		cycle(1'b0, a, wd, unused);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] rdat);
		cycle(1'b1, a, 32'h0, rdat);
	endtask
	// Other FIFO control bits only take with the enable bit set
	task automatic fc_wr(input logic [7:0] cfg);
		wr(5'h08, {24'h0, cfg | 8'h01});
	endtask
endmodule

// file: testbench.sv
// Self-checking bench for the UART interrupt enable, status and FIFO control block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0] tbl;
		logic [7:0] fc;
		logic [6:0] rx;
		logic [6:0] tx;
	} trig_row_t;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [4:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, hang;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic        enh_enable = 1'b0, auto_rts_en = 1'b0, auto_cts_en = 1'b0;
	logic        err_on_entry = 1'b0, rx_err_head = 1'b0, rts_n_out = 1'b0;
	logic        cts_n_pin = 1'b0, bit_tick = 1'b0, tick_on = 1'b0;
	logic [1:0]  trig_table = 2'h0;
	logic [6:0]  trg_rx_prog = 7'h05, trg_tx_prog = 7'h2A;
	logic [6:0]  rx_level = 7'h00, tx_level = 7'h10;
	logic [7:0]  line_status_in = 8'h02;
	logic [3:0]  char_bits = 4'h5;
	logic [11:0] evt = 12'h000;
	logic        irq, sleep_en, fifo_en, rx_fifo_reset, tx_fifo_reset;
	logic [6:0]  rx_trig, tx_trig;
	int          n_fail = 0, checked = 0, nr, nt;
	trig_row_t   rows [13] = '{
		'{2'h0, 8'h01, 7'h01, 7'h01}, '{2'h0, 8'h41, 7'h04, 7'h01}, '{2'h0, 8'h81, 7'h08, 7'h01},
		'{2'h0, 8'hF1, 7'h0E, 7'h01}, '{2'h1, 8'h01, 7'h08, 7'h10}, '{2'h1, 8'h51, 7'h10, 7'h08},
		'{2'h1, 8'hA1, 7'h18, 7'h18}, '{2'h1, 8'hF1, 7'h1C, 7'h1E}, '{2'h2, 8'h01, 7'h08, 7'h08},
		'{2'h2, 8'h51, 7'h10, 7'h10}, '{2'h2, 8'hA1, 7'h38, 7'h20}, '{2'h2, 8'hF1, 7'h3C, 7'h38},
		'{2'h3, 8'hF1, 7'h05, 7'h2A}};

	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) bit_tick <= tick_on;

	uart_irq_ctrl #(.LVL_W(7)) uart_irq_ctrl_i (
		.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .enh_enable, .auto_rts_en, .auto_cts_en, .err_on_entry, .trig_table,
		.trg_rx_prog, .trg_tx_prog, .rx_level, .tx_level, .rx_push(evt[1]),
		.rx_err_entry(evt[2]), .rx_err_head, .overrun_evt(evt[0]), .line_status_in,
		.msr_delta_evt(evt[11:8]), .xon_xoff_evt(evt[3]), .special_evt(evt[4]), .rts_n_out,
		.cts_n_pin, .bit_tick, .char_bits, .rhr_read(evt[5]), .thr_write(evt[6]),
		.wake_evt(evt[7]), .irq, .sleep_en, .fifo_en, .rx_fifo_reset, .tx_fifo_reset,
		.rx_trig, .tx_trig);

	avalon_host avalon_host_i (
		.sys_clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .hang);

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic st(input logic [7:0] e);
		avalon_host_i.rd(5'h04, d);
		cmp(d, {24'h0, e});
	endtask
	task automatic fire(input logic [11:0] m);
		@(posedge sys_clk);
		evt <= m;
		@(posedge sys_clk);
		evt <= 12'h000;
		repeat (3) @(posedge sys_clk);
	endtask
	// Raw write so that a write without the enable bit can be tried too
	task automatic rst_chk(input logic [7:0] cfg, input int er, input int et);
		nr = 0;
		nt = 0;
		avalon_host_i.wr(5'h08, {24'h0, cfg});
		repeat (4) begin
			@(posedge sys_clk);
			if (rx_fifo_reset === 1'b1) nr++;
			if (tx_fifo_reset === 1'b1) nt++;
		end
		cmp(32'(nr), 32'(er));
		cmp(32'(nt), 32'(et));
	endtask

	always @(posedge sys_clk) begin
		if (hang) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		final_report();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		cmp(32'(irq), 32'h0);
		cmp(32'(fifo_en), 32'h0);
		cmp(32'(rx_trig), 32'h1);
		cmp(32'(tx_trig), 32'h1);
		avalon_host_i.rd(5'h00, d);
		cmp(d, 32'h0);
		st(8'h01);
		avalon_host_i.wr(5'h14, 32'hFF);
		avalon_host_i.rd(5'h14, d);
		cmp(d, 32'h0);
		avalon_host_i.rd(5'h08, d);
		cmp(d, 32'h0);
		avalon_host_i.wr(5'h00, 32'hFF);
		avalon_host_i.rd(5'h00, d);
		cmp(d, 32'h0F);
		enh_enable <= 1'b1;
		avalon_host_i.wr(5'h00, 32'h10);
		avalon_host_i.rd(5'h00, d);
		cmp(d, 32'h10);
		cmp(32'(sleep_en), 32'h1);
		avalon_host_i.wr(5'h00, 32'h00);
		avalon_host_i.fc_wr(8'h01);
		st(8'hC1);
		cmp(32'(fifo_en), 32'h1);
		rst_chk(8'h03, 1, 0);
		rst_chk(8'h05, 0, 1);
		rst_chk(8'h02, 0, 0);
		st(8'h01);
		foreach (rows[i]) begin
			trig_table <= rows[i].tbl;
			avalon_host_i.fc_wr(rows[i].fc);
			repeat (3) @(posedge sys_clk);
			cmp(32'(rx_trig), 32'(rows[i].rx));
			cmp(32'(tx_trig), 32'(rows[i].tx));
		end
		trig_table <= 2'h0;
		avalon_host_i.fc_wr(8'h01);
		// Transmit source left off here so stale masked events cannot interfere
		avalon_host_i.wr(5'h00, 32'h0D);
		rx_level <= 7'h02;
		fire(12'h101);
		st(8'hC6);
		cmp(32'(irq), 32'h1);
		avalon_host_i.rd(5'h0C, d);
		cmp(d, 32'h02);
		st(8'hC4);
		rx_level <= 7'h00;
		repeat (3) @(posedge sys_clk);
		st(8'hC0);
		avalon_host_i.rd(5'h10, d);
		cmp(d, 32'h01);
		st(8'hC1);
		repeat (2) @(posedge sys_clk);
		cmp(32'(irq), 32'h0);
		avalon_host_i.wr(5'h00, 32'h00);
		fire(12'h801);
		st(8'hC1);
		cmp(32'(irq), 32'h0);
		avalon_host_i.rd(5'h0C, d);
		avalon_host_i.rd(5'h10, d);
		fire(12'h040);
		avalon_host_i.wr(5'h00, 32'h02);
		st(8'hC1);
		tx_level <= 7'h00;
		repeat (3) @(posedge sys_clk);
		st(8'hC2);
		st(8'hC1);
		avalon_host_i.wr(5'h00, 32'h00);
		avalon_host_i.wr(5'h00, 32'h02);
		st(8'hC2);
		fire(12'h040);
		st(8'hC1);
		tx_level <= 7'h10;
		trig_table <= 2'h1;
		avalon_host_i.fc_wr(8'h01);
		avalon_host_i.wr(5'h00, 32'h01);
		rx_level <= 7'h02;
		fire(12'h002);
		// Five-bit characters: timeout after 32 bit times
		tick_on <= 1'b1;
		repeat (16) @(posedge sys_clk);
		st(8'hC1);
		repeat (30) @(posedge sys_clk);
		tick_on <= 1'b0;
		st(8'hCC);
		fire(12'h020);
		st(8'hC1);
		rx_level <= 7'h08;
		repeat (3) @(posedge sys_clk);
		st(8'hC4);
		rx_level <= 7'h07;
		repeat (3) @(posedge sys_clk);
		st(8'hC1);
		rx_level <= 7'h00;
		avalon_host_i.wr(5'h00, 32'h04);
		err_on_entry <= 1'b1;
		fire(12'h004);
		st(8'hC6);
		avalon_host_i.rd(5'h0C, d);
		err_on_entry <= 1'b0;
		fire(12'h004);
		st(8'hC1);
		rx_err_head <= 1'b1;
		repeat (3) @(posedge sys_clk);
		st(8'hC6);
		rx_err_head <= 1'b0;
		avalon_host_i.rd(5'h0C, d);
		st(8'hC1);
		avalon_host_i.wr(5'h00, 32'h20);
		fire(12'h008);
		st(8'hD0);
		st(8'hC1);
		fire(12'h010);
		cmp(32'(irq), 32'h1);
		fire(12'h002);
		st(8'hC1);
		avalon_host_i.wr(5'h00, 32'hC0);
		auto_rts_en <= 1'b1;
		auto_cts_en <= 1'b1;
		@(posedge sys_clk);
		rts_n_out <= 1'b1;
		repeat (3) @(posedge sys_clk);
		st(8'hE0);
		avalon_host_i.rd(5'h10, d);
		st(8'hC1);
		avalon_host_i.wr(5'h00, 32'h40);
		cts_n_pin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		st(8'hC1);
		cts_n_pin <= 1'b0;
		avalon_host_i.wr(5'h00, 32'hC0);
		cts_n_pin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		st(8'hE0);
		avalon_host_i.rd(5'h10, d);
		st(8'hC1);
		avalon_host_i.wr(5'h00, 32'h00);
		avalon_host_i.fc_wr(8'h08);
		fire(12'h080);
		cmp(32'(irq), 32'h1);
		st(8'hC1);
		repeat (2) @(posedge sys_clk);
		cmp(32'(irq), 32'h0);
		final_report();
	end
endmodule

// file: uart_irq_ctrl.sv
// Interrupt enable, prioritised interrupt status and FIFO control of the UART
module uart_irq_ctrl #(
	parameter int LVL_W = 7
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [4:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             enh_enable,
	input  wire logic             auto_rts_en,
	input  wire logic             auto_cts_en,
	input  wire logic             err_on_entry,
	input  wire logic [1:0]       trig_table,
	input  wire logic [LVL_W-1:0] trg_rx_prog,
	input  wire logic [LVL_W-1:0] trg_tx_prog,
	input  wire logic [LVL_W-1:0] rx_level,
	input  wire logic [LVL_W-1:0] tx_level,
	input  wire logic             rx_push,
	input  wire logic             rx_err_entry,
	input  wire logic             rx_err_head,
	input  wire logic             overrun_evt,
	input  wire logic [7:0]       line_status_in,
	input  wire logic [3:0]       msr_delta_evt,
	input  wire logic             xon_xoff_evt,
	input  wire logic             special_evt,
	input  wire logic             rts_n_out,
	input  wire logic             cts_n_pin,
	input  wire logic             bit_tick,
	input  wire logic [3:0]       char_bits,
	input  wire logic             rhr_read,
	input  wire logic             thr_write,
	input  wire logic             wake_evt,
	output logic                  irq,
	output logic                  sleep_en,
	output logic                  fifo_en,
	output logic                  rx_fifo_reset,
	output logic                  tx_fifo_reset,
	output logic      [LVL_W-1:0] rx_trig,
	output logic      [LVL_W-1:0] tx_trig
);
	if (LVL_W != 7) begin : g_lvl_check
		$error("LVL_W must be 7 to hold trigger levels up to 64");
	end

	logic [7:0]       ie_r;
	logic [7:0]       fc_r;
	logic [3:0]       ms_r;
	logic             ack_r;
	logic             ls_pend_r;
	logic             to_pend_r;
	logic             tx_pend_r;
	logic             flow_pend_r;
	logic             spec_pend_r;
	logic             cr_pend_r;
	logic             wake_pend_r;
	logic [7:0]       to_cnt_r;
	logic             to_done_r;
	logic             tx_below_r;
	logic             tx_empty_r;
	logic             rts_d_r;
	logic             cts_s1_r;
	logic             cts_s2_r;
	logic             cts_d_r;
	logic [5:0]       src_r;
	logic             irq_r;
	logic [31:0]      rdata_r;
	logic [5:0]       src_nxt;
	logic [6:0]       pend;
	logic             rx_cond;
	logic             tx_evt;
	logic             acc_rd;
	logic             acc_wr;
	logic [2:0]       idx;
	logic [7:0]       to_limit;
	logic [LVL_W-1:0] rx_trig_nxt;
	logic [LVL_W-1:0] tx_trig_nxt;

	function automatic logic [LVL_W-1:0] pick(input logic [27:0] tab, input logic [1:0] sel);
		pick = tab[7 * sel +: 7];
	endfunction

	function automatic logic [LVL_W-1:0] trig_lookup(input logic [1:0] tbl, input logic [1:0] sel,
		input logic tx, input logic [LVL_W-1:0] prog);
		case (tbl)
			uart_irq_pkg::TBL_A: trig_lookup = pick(tx ? uart_irq_pkg::TX_TAB_A
				: uart_irq_pkg::RX_TAB_A, sel);
			uart_irq_pkg::TBL_B: trig_lookup = pick(tx ? uart_irq_pkg::TX_TAB_B
				: uart_irq_pkg::RX_TAB_B, sel);
			uart_irq_pkg::TBL_C: trig_lookup = pick(tx ? uart_irq_pkg::TX_TAB_C
				: uart_irq_pkg::RX_TAB_C, sel);
			default: trig_lookup = prog;
		endcase
	endfunction

	// Bus: one wait cycle, then the access completes; side effects only on that edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign acc_rd = avs_read & ack_r;
	assign acc_wr = avs_write & ack_r;
	assign idx = avs_address[4:2];
	assign avs_readdata = rdata_r;

	always_ff @(posedge sys_clk) begin
		if (reset)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	// Enhanced enables cannot change while enhanced functions are off
	always_ff @(posedge sys_clk) begin
		if (reset)
			ie_r <= uart_irq_pkg::IE_RESET;
		else if (acc_wr && idx == uart_irq_pkg::IDX_IE)
			ie_r <= enh_enable ? avs_writedata[7:0]
				: (ie_r & uart_irq_pkg::ENH_MASK) | (avs_writedata[7:0] & ~uart_irq_pkg::ENH_MASK);
	end

	// A write without the enable bit only switches the FIFOs off
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fc_r <= uart_irq_pkg::FC_RESET;
		end else if (acc_wr && idx == uart_irq_pkg::IDX_FC) begin
			if (avs_writedata[uart_irq_pkg::FC_EN]) begin
				fc_r[7:6] <= avs_writedata[7:6];
				if (enh_enable)
					fc_r[5:3] <= avs_writedata[5:3];
				fc_r[2:0] <= 3'h1;
			end else begin
				fc_r[uart_irq_pkg::FC_EN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_fifo_reset <= 1'b0;
			tx_fifo_reset <= 1'b0;
		end else begin
			rx_fifo_reset <= acc_wr && idx == uart_irq_pkg::IDX_FC
				&& avs_writedata[uart_irq_pkg::FC_EN] && avs_writedata[uart_irq_pkg::FC_RXRST];
			tx_fifo_reset <= acc_wr && idx == uart_irq_pkg::IDX_FC
				&& avs_writedata[uart_irq_pkg::FC_EN] && avs_writedata[uart_irq_pkg::FC_TXRST];
		end
	end

	assign fifo_en = fc_r[uart_irq_pkg::FC_EN];
	assign sleep_en = ie_r[uart_irq_pkg::IE_SLEEP];
	assign rx_trig_nxt = trig_lookup(trig_table, fc_r[7:6], 1'b0, trg_rx_prog);
	assign tx_trig_nxt = trig_lookup(trig_table, fc_r[5:4], 1'b1, trg_tx_prog);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_trig <= pick(uart_irq_pkg::RX_TAB_A, 2'h0);
			tx_trig <= pick(uart_irq_pkg::TX_TAB_A, 2'h0);
		end else begin
			rx_trig <= rx_trig_nxt;
			tx_trig <= tx_trig_nxt;
		end
	end

	// Clear-to-send arrives from a pin
	// Reset high: a line already high after reset must not look like a rise
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cts_s1_r <= 1'b1;
			cts_s2_r <= 1'b1;
			cts_d_r <= 1'b1;
			rts_d_r <= 1'b1;
		end else begin
			cts_s1_r <= cts_n_pin;
			cts_s2_r <= cts_s1_r;
			cts_d_r <= cts_s2_r;
			rts_d_r <= rts_n_out;
		end
	end

	// Sticky sources: in every one the set term wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset)
			ls_pend_r <= 1'b0;
		else if (overrun_evt || (err_on_entry ? rx_err_entry : rx_err_head))
			ls_pend_r <= 1'b1;
		else if (acc_rd && idx == uart_irq_pkg::IDX_LS)
			ls_pend_r <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			ms_r <= 4'h0;
		else if (acc_rd && idx == uart_irq_pkg::IDX_MS)
			ms_r <= msr_delta_evt;
		else
			ms_r <= ms_r | msr_delta_evt;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			cr_pend_r <= 1'b0;
		else if ((auto_rts_en && ie_r[uart_irq_pkg::IE_RTS] && rts_n_out && !rts_d_r)
			|| (auto_cts_en && ie_r[uart_irq_pkg::IE_CTS] && cts_s2_r && !cts_d_r))
			cr_pend_r <= 1'b1;
		else if (acc_rd && idx == uart_irq_pkg::IDX_MS)
			cr_pend_r <= 1'b0;
	end

	// Timeout: restarted by any receive activity, counted in bit ticks
	assign to_limit = uart_irq_pkg::TO_CHARS * {4'h0, char_bits} + uart_irq_pkg::TO_BITS;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			to_cnt_r <= 8'h00;
			to_done_r <= 1'b0;
		end else if (rx_push || rhr_read || rx_level == '0) begin
			to_cnt_r <= 8'h00;
			to_done_r <= 1'b0;
		end else if (bit_tick && !to_done_r) begin
			to_cnt_r <= to_cnt_r + 8'h01;
			to_done_r <= to_cnt_r + 8'h01 >= to_limit;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			to_pend_r <= 1'b0;
		else if (bit_tick && !to_done_r && to_cnt_r + 8'h01 >= to_limit && !rx_push
			&& rx_level != '0 && fifo_en)
			to_pend_r <= 1'b1;
		else if (rhr_read)
			to_pend_r <= 1'b0;
	end

	assign rx_cond = fifo_en ? rx_level >= rx_trig : rx_level != '0;

	// Below-trigger and empty edges cover a reload that never passed the trigger
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_below_r <= 1'b1;
			tx_empty_r <= 1'b1;
		end else begin
			tx_below_r <= tx_level < tx_trig;
			tx_empty_r <= tx_level == '0;
		end
	end

	assign tx_evt = (fifo_en && tx_level < tx_trig && !tx_below_r)
		|| (tx_level == '0 && !tx_empty_r)
		|| (acc_wr && idx == uart_irq_pkg::IDX_IE && avs_writedata[uart_irq_pkg::IE_TX]
			&& !ie_r[uart_irq_pkg::IE_TX] && tx_level == '0);

	always_ff @(posedge sys_clk) begin
		if (reset)
			tx_pend_r <= 1'b0;
		else if (tx_evt)
			tx_pend_r <= 1'b1;
		else if (thr_write || (acc_rd && idx == uart_irq_pkg::IDX_IS && src_r == uart_irq_pkg::CODE_TX))
			tx_pend_r <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			flow_pend_r <= 1'b0;
		else if (xon_xoff_evt)
			flow_pend_r <= 1'b1;
		else if (acc_rd && idx == uart_irq_pkg::IDX_IS && src_r == uart_irq_pkg::CODE_FLOW)
			flow_pend_r <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			spec_pend_r <= 1'b0;
		else if (special_evt)
			spec_pend_r <= 1'b1;
		else if (rx_push || (acc_rd && idx == uart_irq_pkg::IDX_IS && src_r == uart_irq_pkg::CODE_FLOW))
			spec_pend_r <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			wake_pend_r <= 1'b0;
		else if (wake_evt && fc_r[uart_irq_pkg::FC_WAKE])
			wake_pend_r <= 1'b1;
		else if (acc_rd && idx == uart_irq_pkg::IDX_IS)
			wake_pend_r <= 1'b0;
	end

	// Enabled view of each source except wakeup, highest priority in bit 6
	assign pend = {ls_pend_r & ie_r[uart_irq_pkg::IE_LS],
		to_pend_r & ie_r[uart_irq_pkg::IE_RX],
		rx_cond & ie_r[uart_irq_pkg::IE_RX],
		tx_pend_r & ie_r[uart_irq_pkg::IE_TX],
		(|ms_r) & ie_r[uart_irq_pkg::IE_MS],
		(flow_pend_r | spec_pend_r) & ie_r[uart_irq_pkg::IE_FLOW] & enh_enable,
		cr_pend_r & (ie_r[uart_irq_pkg::IE_RTS] | ie_r[uart_irq_pkg::IE_CTS]) & enh_enable};

	always_comb begin
		if (pend[6])
			src_nxt = uart_irq_pkg::CODE_LS;
		else if (pend[5])
			src_nxt = uart_irq_pkg::CODE_TO;
		else if (pend[4])
			src_nxt = uart_irq_pkg::CODE_RX;
		else if (pend[3])
			src_nxt = uart_irq_pkg::CODE_TX;
		else if (pend[2])
			src_nxt = uart_irq_pkg::CODE_MS;
		else if (pend[1])
			src_nxt = uart_irq_pkg::CODE_FLOW;
		else if (pend[0])
			src_nxt = uart_irq_pkg::CODE_CR;
		else
			src_nxt = uart_irq_pkg::CODE_NONE;
	end

	// Snapshot taken in the wait cycle so the clear matches what the host saw
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			src_r <= uart_irq_pkg::CODE_NONE;
			rdata_r <= 32'h0000_0000;
		end else if (avs_read && !ack_r) begin
			src_r <= src_nxt;
			case (idx)
				uart_irq_pkg::IDX_IE: rdata_r <= {24'h00_0000, ie_r};
				uart_irq_pkg::IDX_IS: rdata_r <= {24'h00_0000, {2{fifo_en}}, src_nxt};
				uart_irq_pkg::IDX_LS: rdata_r <= {24'h00_0000, line_status_in};
				uart_irq_pkg::IDX_MS: rdata_r <= {28'h000_0000, ms_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			irq_r <= 1'b0;
		else
			irq_r <= (|pend) | wake_pend_r;
	end

	assign irq = irq_r;

	sequence s_fc_reset_write;
		acc_wr && idx == uart_irq_pkg::IDX_FC && avs_writedata[uart_irq_pkg::FC_EN]
			&& avs_writedata[uart_irq_pkg::FC_RXRST];
	endsequence

	sequence s_pulse_once;
		rx_fifo_reset ##1 !rx_fifo_reset;
	endsequence

	chk_bus_wait_one: assert property (@(posedge sys_clk) disable iff (reset)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access not completed after one wait cycle");
	chk_overrun_sets_ls: assert property (@(posedge sys_clk) disable iff (reset)
		overrun_evt |=> ls_pend_r)
		else $error("overrun did not flag line status");
	chk_entry_err_sets: assert property (@(posedge sys_clk) disable iff (reset)
		err_on_entry && rx_err_entry |=> ls_pend_r)
		else $error("entry error did not flag line status");
	chk_modem_gate: assert property (@(posedge sys_clk) disable iff (reset)
		(|ms_r) && !ie_r[uart_irq_pkg::IE_MS] && pend[6:3] == 4'h0 && pend[1:0] == 2'h0
			|-> src_nxt == uart_irq_pkg::CODE_NONE)
		else $error("modem source pending while disabled");
	chk_enh_lock: assert property (@(posedge sys_clk) disable iff (reset)
		acc_wr && idx == uart_irq_pkg::IDX_IE && !enh_enable |=> ie_r[7:4] == $past(ie_r[7:4]))
		else $error("enhanced enable bits changed while locked");
	chk_fifo_rst_pulse: assert property (@(posedge sys_clk) disable iff (reset)
		s_fc_reset_write |=> s_pulse_once)
		else $error("receive FIFO reset not a single pulse");
	chk_status_top_bits: assert property (@(posedge sys_clk) disable iff (reset)
		acc_rd && idx == uart_irq_pkg::IDX_IS |-> avs_readdata[7:6] == {2{fifo_en}})
		else $error("status top bits disagree with FIFO enable");
	chk_thr_clears_tx: assert property (@(posedge sys_clk) disable iff (reset)
		thr_write && !tx_evt |=> !tx_pend_r)
		else $error("holding write did not clear transmit ready");
	chk_rts_rise: assert property (@(posedge sys_clk) disable iff (reset)
		auto_rts_en && ie_r[uart_irq_pkg::IE_RTS] && $rose(rts_n_out) |=> cr_pend_r)
		else $error("request-to-send rise not flagged");
	chk_ls_priority: assert property (@(posedge sys_clk) disable iff (reset)
		pend[6] |-> src_nxt == uart_irq_pkg::CODE_LS)
		else $error("line status not top priority");
endmodule

// file: uart_irq_pkg.sv
// Register map, field layout, interrupt codes and trigger tables of the UART interrupt block
// Behaviour
// - Line-status enable: overrun interrupts at once, other errors when at holding position.
// - Error-timing bit set: receive errors interrupt when the character enters the FIFO.
// - Enable bit 3 gates the modem-status interrupt; off after reset.
// - Enable bit 4 is sleep; bits 7:4 writable only with enhanced functions on.
// - Enable bit 5 gates the flow-control stop character interrupt; off after reset.
// - Enable bit 6 with auto request-to-send: interrupt on its low-to-high edge.
// - Enable bit 7 with auto clear-to-send: interrupt on its low-to-high edge.
// - Status read shows only the highest pending source; others except wakeup stay queued.
// - Status codes: 06,0C,04,02,00,10,20 in priority order; 01 when none or wakeup.
// - Receive timeout after four characters plus twelve bits; holding read clears it.
// - Transmit ready on trigger or empty; cleared by status read or holding write.
// - Modem read clears modem and flow-edge interrupts; line read clears line interrupt.
// - Receive ready follows trigger level and clears once level drops below it.
// - Status read clears flow characters; special character also clears on next character.
// - Wakeup interrupt on leaving sleep, enabled by FIFO control bit 3, status read clears.
// - Status bits 7:6 read 11 with FIFOs enabled, 00 when disabled.
// - Modem-status interrupt raised when any modem delta bit 3:0 is set.
// - FIFO control bits 1/2 reset receive/transmit FIFO pointers and self-clear.
// - Transmit interrupt when level falls below trigger, or on empty if never above.
// - Receive interrupt when the receive level crosses the selected trigger.
// - Table selector picks tables A to C or the programmed levels; both directions share it.
// - Enable bit 1 set while transmit side empty interrupts immediately.
package uart_irq_pkg;
	localparam logic [2:0] IDX_IE = 3'h0;
	localparam logic [2:0] IDX_IS = 3'h1;
	localparam logic [2:0] IDX_FC = 3'h2;
	localparam logic [2:0] IDX_LS = 3'h3;
	localparam logic [2:0] IDX_MS = 3'h4;
	localparam int IE_RX    = 0;
	localparam int IE_TX    = 1;
	localparam int IE_LS    = 2;
	localparam int IE_MS    = 3;
	localparam int IE_SLEEP = 4;
	localparam int IE_FLOW  = 5;
	localparam int IE_RTS   = 6;
	localparam int IE_CTS   = 7;
	localparam int FC_EN    = 0;
	localparam int FC_RXRST = 1;
	localparam int FC_TXRST = 2;
	localparam int FC_WAKE  = 3;
	localparam logic [7:0] IE_RESET = 8'h00;
	localparam logic [7:0] FC_RESET = 8'h00;
	localparam logic [7:0] ENH_MASK = 8'hF0;
	localparam logic [5:0] CODE_LS   = 6'h06;
	localparam logic [5:0] CODE_TO   = 6'h0C;
	localparam logic [5:0] CODE_RX   = 6'h04;
	localparam logic [5:0] CODE_TX   = 6'h02;
	localparam logic [5:0] CODE_MS   = 6'h00;
	localparam logic [5:0] CODE_FLOW = 6'h10;
	localparam logic [5:0] CODE_CR   = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [1:0] TBL_A = 2'h0;
	localparam logic [1:0] TBL_B = 2'h1;
	localparam logic [1:0] TBL_C = 2'h2;
	localparam logic [27:0] RX_TAB_A = {7'h0E, 7'h08, 7'h04, 7'h01};
	localparam logic [27:0] RX_TAB_B = {7'h1C, 7'h18, 7'h10, 7'h08};
	localparam logic [27:0] RX_TAB_C = {7'h3C, 7'h38, 7'h10, 7'h08};
	localparam logic [27:0] TX_TAB_A = {7'h01, 7'h01, 7'h01, 7'h01};
	localparam logic [27:0] TX_TAB_B = {7'h1E, 7'h18, 7'h08, 7'h10};
	localparam logic [27:0] TX_TAB_C = {7'h38, 7'h20, 7'h10, 7'h08};
	localparam logic [7:0] TO_CHARS = 8'h04;
	localparam logic [7:0] TO_BITS  = 8'h0C;
endpackage
